/* File: logic/rtpi_core.sv */
// module: periodic interrupt generator and oscillator halt detector
//
// How it works
// R1 - host control write clears halt flag
// R2 - oscillator stop sets halt flag
// R3 - power-up reset presets halt flag to one
// R4 - CE high freezes halt detection
// R5 - halt flag sticky until host clears
// R6 - CE held 2.5 s gives 1 Hz
// R7 - CE under 1.5 s gives no pulse
// R8 - irq output is active-low open drain
// R9 - select bit 3 picks pulse or level
// R10 - pulse codes 00 off, 01 low
// R11 - pulse codes 10 1024 Hz, 11 2 Hz
// R12 - level codes 000-011 second to ten minutes
// R13 - level code 100 every hour
// R14 - level codes 101-111 day, week, month
// R15 - pulse mode flag mirrors output, read-only
// R16 - level mode flag writable, drives output
// R17 - writing flag zero releases output
// R18 - boundary sets flag, held until cleared
// R19 - waveforms divided from oscillator clock
`timescale 1ns/100ps
`default_nettype none
module rtpi_core #(
   parameter int unsigned HALT_CYC = rtpi_pkg::HALT_CYC,
   parameter int unsigned MEAS_CYC = rtpi_pkg::MEAS_HOLD_CYC
) (
   input  wire logic                       CLK,
   input  wire logic                       RESET_N,
   input  wire logic                       CE,
   input  wire logic                       OSC_INPUT,
   input  wire rtpi_pkg::rtpi_host_wr_type HOST_WR,
   input  wire rtpi_pkg::rtpi_time_evt_type TIME_EVT,
   output logic                            IRQ_OUT_N_O,
   output logic                            IRQ_OUT_N_OE,
   output logic                            OSC_HALT_FLAG,
   output logic                            PERIODIC_IRQ_FLAG,
   output logic [3:0]                      INTERRUPT_CYCLE_SELECT
);

   // state of the output selection
   typedef enum logic [1:0] {
      RTPI_NORMAL,
      RTPI_MEASURE
   } rtpi_mode_type;

   logic                      ce_s1;          // first sync stage, CE
   logic                      ce_s2;          // synchronised CE
   logic                      osc_s1;         // first sync stage, osc
   logic                      osc_s2;         // synchronised osc
   logic                      osc_d;          // delayed for edge detect
   logic                      osc_rise;       // one osc rising edge
   logic [rtpi_pkg::DIV_W-1:0] div;           // oscillator divider
   logic [12:0]               halt_cnt;       // cycles since last osc edge
   logic                      halt_seen;      // timeout reached
   logic [27:0]               ce_cnt;         // cycles CE has stayed high
   rtpi_mode_type             mode;           // normal or measurement
   logic                      level_mode;     // select bit 3
   logic [1:0]                period;         // low two select bits
   logic                      boundary;       // selected level-mode event
   logic                      next_oe;        // pull line low next cycle

   // pick the boundary pulse for a level-mode code
   function automatic logic pick_evt(input logic [2:0] code,
                                     input rtpi_pkg::rtpi_time_evt_type e);
      logic r;
      r = 1'b0;
      case (code)
         3'h0:    r = e.every_sec;          // [R12]
         3'h1:    r = e.every_10s;          // [R12]
         3'h2:    r = e.every_min;          // [R12]
         3'h3:    r = e.every_10min;        // [R12]
         3'h4:    r = e.every_hour;         // [R13]
         3'h5:    r = e.every_day;          // [R14]
         3'h6:    r = e.every_week;         // [R14]
         3'h7:    r = e.every_month;        // [R14]
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // pin synchronisers; first stages feed only the second
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ce_s1  <= 1'b0;
         ce_s2  <= 1'b0;
         osc_s1 <= 1'b0;
         osc_s2 <= 1'b0;
         osc_d  <= 1'b0;
      end else begin
         ce_s1  <= CE;
         ce_s2  <= ce_s1;
         osc_s1 <= OSC_INPUT;
         osc_s2 <= osc_s1;
         osc_d  <= osc_s2;
      end
   end

   assign osc_rise = osc_s2 & ~osc_d;

   // oscillator divider, all waveforms tap it
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         div <= '0;
      end else if (osc_rise) begin
         div <= div + 1'b1;                 // [R19]
      end
   end

   // halt watchdog; held at zero while CE is high so access cannot trip it
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         halt_cnt <= '0;
      end else if (osc_rise || ce_s2) begin
         halt_cnt <= '0;                    // [R4]
      end else if (!halt_seen) begin
         halt_cnt <= halt_cnt + 13'h1;
      end
   end

   assign halt_seen = (halt_cnt >= 13'(HALT_CYC));

   // halt flag: reset to one, set by timeout, cleared by control write
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         OSC_HALT_FLAG <= rtpi_pkg::HALT_RESET;      // [R3]
      end else if (halt_seen && !ce_s2) begin
         OSC_HALT_FLAG <= 1'b1;             // set wins over clear [R2] [R5]
      end else if (HOST_WR.ctrl_wr) begin
         OSC_HALT_FLAG <= 1'b0;             // [R1]
      end
   end

   // CE hold timer; short holds never reach the limit
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ce_cnt <= '0;
      end else if (!ce_s2) begin
         ce_cnt <= '0;                      // [R7]
      end else if (ce_cnt < 28'(MEAS_CYC)) begin
         ce_cnt <= ce_cnt + 28'h1;
      end
   end

   // measurement state follows the CE hold timer
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         mode <= RTPI_NORMAL;
      end else begin
         case (mode)
            RTPI_NORMAL:
               if (ce_s2 && ce_cnt >= 28'(MEAS_CYC)) begin
                  mode <= RTPI_MEASURE;     // [R6]
               end
            RTPI_MEASURE:
               if (!ce_s2) begin
                  mode <= RTPI_NORMAL;
               end
            default: mode <= RTPI_NORMAL;
         endcase
      end
   end

   // interrupt cycle select register
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         INTERRUPT_CYCLE_SELECT <= rtpi_pkg::CYC_RESET;
      end else if (HOST_WR.cyc_wr) begin
         INTERRUPT_CYCLE_SELECT <= HOST_WR.cyc_data;
      end
   end

   assign level_mode = INTERRUPT_CYCLE_SELECT[rtpi_pkg::CYC_MODE_BIT]; // [R9]
   assign period     = INTERRUPT_CYCLE_SELECT[1:0];
   assign boundary   = pick_evt(INTERRUPT_CYCLE_SELECT[2:0], TIME_EVT);

   // output drive decision
   always_comb begin
      next_oe = 1'b0;
      if (mode == RTPI_MEASURE) begin
         next_oe = div[rtpi_pkg::TAP_1HZ];            // [R6] [R19]
      end else if (level_mode) begin
         next_oe = PERIODIC_IRQ_FLAG;                 // [R16] [R17]
      end else begin
         case (period)                                // bit 2 ignored
            rtpi_pkg::PER_OFF:    next_oe = 1'b0;     // [R10]
            rtpi_pkg::PER_ON:     next_oe = 1'b1;     // [R10]
            rtpi_pkg::PER_1024HZ:
               next_oe = div[rtpi_pkg::TAP_1024HZ];   // [R11]
            rtpi_pkg::PER_2HZ:
               next_oe = div[rtpi_pkg::TAP_2HZ];      // [R11]
            default:              next_oe = 1'b0;
         endcase
      end
   end

   // open-drain line: data always low, only the enable moves
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         IRQ_OUT_N_O  <= 1'b0;
         IRQ_OUT_N_OE <= 1'b0;
      end else begin
         IRQ_OUT_N_O  <= 1'b0;              // [R8]
         IRQ_OUT_N_OE <= next_oe;           // [R8]
      end
   end

   // periodic irq flag; pulse mode mirrors the line, level mode latches
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         PERIODIC_IRQ_FLAG <= rtpi_pkg::PIF_RESET;
      end else if (!level_mode) begin
         PERIODIC_IRQ_FLAG <= next_oe;      // writes ignored [R15]
      end else if (boundary) begin
         PERIODIC_IRQ_FLAG <= 1'b1;         // set beats a same-cycle ack [R18]
      end else if (HOST_WR.pif_wr) begin
         PERIODIC_IRQ_FLAG <= HOST_WR.pif_data; // [R16] [R17]
      end
   end

   // checks next to the logic they guard
   a_halt_sets: assert property (@(posedge CLK) disable iff (!RESET_N)
      halt_seen && !ce_s2 |=> OSC_HALT_FLAG)                   // [R2]
      else $error("halt timeout did not set halt flag");

   a_halt_sticky: assert property (@(posedge CLK) disable iff (!RESET_N)
      OSC_HALT_FLAG && !HOST_WR.ctrl_wr |=> OSC_HALT_FLAG)     // [R5]
      else $error("halt flag dropped without host clear");

   a_halt_clear: assert property (@(posedge CLK) disable iff (!RESET_N)
      HOST_WR.ctrl_wr && !(halt_seen && !ce_s2)
      |=> !OSC_HALT_FLAG)                                      // [R1]
      else $error("control write did not clear halt flag");

   a_ce_freeze: assert property (@(posedge CLK) disable iff (!RESET_N)
      ce_s2 && !HOST_WR.ctrl_wr |=> $stable(OSC_HALT_FLAG))    // [R4]
      else $error("halt flag moved while CE high");

   a_meas_short: assert property (@(posedge CLK) disable iff (!RESET_N)
      !ce_s2 ##1 ce_s2 |-> mode == RTPI_NORMAL)                // [R7]
      else $error("measurement began without CE hold");

   a_meas_entry: assert property (@(posedge CLK) disable iff (!RESET_N)
      ce_s2 && ce_cnt >= 28'(MEAS_CYC) |=> mode == RTPI_MEASURE) // [R6]
      else $error("CE hold did not start measurement");

   a_meas_wave: assert property (@(posedge CLK) disable iff (!RESET_N)
      mode == RTPI_MEASURE
      |=> IRQ_OUT_N_OE == $past(div[rtpi_pkg::TAP_1HZ]))       // [R6]
      else $error("measurement output not 1 Hz tap");

   a_od_low: assert property (@(posedge CLK) disable iff (!RESET_N)
      ##1 !IRQ_OUT_N_O)                                        // [R8]
      else $error("open-drain data not low");

   a_pulse_off: assert property (@(posedge CLK) disable iff (!RESET_N)
      mode == RTPI_NORMAL && !level_mode && period == 2'h0
      |=> !IRQ_OUT_N_OE)                                       // [R10]
      else $error("pulse off code drove the line");

   a_pulse_on: assert property (@(posedge CLK) disable iff (!RESET_N)
      mode == RTPI_NORMAL && !level_mode && period == 2'h1
      |=> IRQ_OUT_N_OE)                                        // [R10]
      else $error("pulse on code released the line");

   a_pulse_fast: assert property (@(posedge CLK) disable iff (!RESET_N)
      mode == RTPI_NORMAL && !level_mode && period == 2'h2
      |=> IRQ_OUT_N_OE == $past(div[4]))                       // [R11]
      else $error("1024 Hz output not on divider tap");

   a_pulse_slow: assert property (@(posedge CLK) disable iff (!RESET_N)
      mode == RTPI_NORMAL && !level_mode && period == 2'h3
      |=> IRQ_OUT_N_OE == $past(div[rtpi_pkg::TAP_2HZ]))       // [R11]
      else $error("2 Hz output not on divider tap");

   a_pulse_flag: assert property (@(posedge CLK) disable iff (!RESET_N)
      !level_mode |=> PERIODIC_IRQ_FLAG == IRQ_OUT_N_OE)       // [R15]
      else $error("pulse mode flag differs from line");

   a_level_set: assert property (@(posedge CLK) disable iff (!RESET_N)
      level_mode && boundary |=> PERIODIC_IRQ_FLAG)            // [R18]
      else $error("boundary did not set periodic flag");

   a_level_ack: assert property (@(posedge CLK) disable iff (!RESET_N)
      level_mode && mode == RTPI_NORMAL && HOST_WR.pif_wr
      && !HOST_WR.pif_data && !boundary && !HOST_WR.cyc_wr
      |=> !PERIODIC_IRQ_FLAG ##1 !IRQ_OUT_N_OE)                // [R17]
      else $error("ack did not release the line");

   a_level_drive: assert property (@(posedge CLK) disable iff (!RESET_N)
      level_mode && mode == RTPI_NORMAL
      |=> IRQ_OUT_N_OE == $past(PERIODIC_IRQ_FLAG))            // [R16]
      else $error("level mode line not following flag");

   a_hour_code: assert property (@(posedge CLK) disable iff (!RESET_N)
      INTERRUPT_CYCLE_SELECT == 4'hC && TIME_EVT.every_hour
      |=> PERIODIC_IRQ_FLAG)                                   // [R13]
      else $error("hourly code missed hour boundary");

   a_sec_code: assert property (@(posedge CLK) disable iff (!RESET_N)
      INTERRUPT_CYCLE_SELECT == 4'h8 && TIME_EVT.every_sec
      |=> PERIODIC_IRQ_FLAG)                                   // [R12]
      else $error("seconds code missed second boundary");

   a_month_code: assert property (@(posedge CLK) disable iff (!RESET_N)
      INTERRUPT_CYCLE_SELECT == 4'hF && TIME_EVT.every_month
      |=> PERIODIC_IRQ_FLAG)                                   // [R14]
      else $error("monthly code missed month boundary");

endmodule
`default_nettype wire

/* File: logic/rtpi_pkg.sv */
// package: constants and carrier types of the periodic irq / halt block
`default_nettype none
package rtpi_pkg;
   // clock rate
   localparam int unsigned CLK_PERIOD_NS = 20;            // 50 MHz system clock
   // oscillator halt: no oscillator edge for this long means stopped
   localparam int unsigned HALT_TIME_NS  = 122000;        // about 4 osc periods
   localparam int unsigned HALT_CYC      = HALT_TIME_NS / CLK_PERIOD_NS;
   // chip enable hold time before frequency measurement output
   localparam longint unsigned MEAS_HOLD_NS = 64'd2500000000; // 2.5 s
   localparam int unsigned MEAS_HOLD_CYC =
      int'((MEAS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // oscillator divider taps (32.768 kHz source)
   localparam int unsigned DIV_W         = 15;            // 32768 edges = 1 s
   localparam int unsigned TAP_1024HZ    = 4;             // 32-edge period
   localparam int unsigned TAP_2HZ       = 13;            // 16384-edge period
   localparam int unsigned TAP_1HZ       = 14;            // 32768-edge period
   // interrupt cycle select field layout
   localparam int unsigned CYC_MODE_BIT  = 3;             // 1 = level mode
   localparam logic [3:0]  CYC_RESET     = 4'h0;          // pulse mode, off
   // pulse mode period codes (low two bits)
   localparam logic [1:0]  PER_OFF       = 2'h0;
   localparam logic [1:0]  PER_ON        = 2'h1;
   localparam logic [1:0]  PER_1024HZ    = 2'h2;
   localparam logic [1:0]  PER_2HZ       = 2'h3;
   // reset values of the flags
   localparam logic        HALT_RESET    = 1'b1;          // set on power-up
   localparam logic        PIF_RESET     = 1'b0;

   // one-cycle time boundary pulses from the calendar counters
   typedef struct packed {
      logic every_month;     // 1st day 0:00:00
      logic every_week;      // weekday 0 at 0:00:00
      logic every_day;       // 0:00:00
      logic every_hour;      // mm:ss = 00:00
      logic every_10min;     // minute ends in 0, second 00
      logic every_min;       // second 00
      logic every_10s;       // second ends in 0
      logic every_sec;       // each second
   } rtpi_time_evt_type;

   // host write strobes coming out of the serial port decoder
   typedef struct packed {
      logic       cyc_wr;    // interrupt cycle select write
      logic [3:0] cyc_data;  // new select value
      logic       ctrl_wr;   // control register write, clears halt flag
      logic       pif_wr;    // periodic irq flag write
      logic       pif_data;  // value written to the flag
   } rtpi_host_wr_type;
endpackage
`default_nettype wire

/* File: testbench/rtpi_host_model.sv */
// host cpu model: register write strobes and pulled-up irq line
`timescale 1ns/100ps
`default_nettype none
module rtpi_host_model (
   input  wire logic                        clk,
   input  wire logic                        irq_o,
   input  wire logic                        irq_oe,
   output var  rtpi_pkg::rtpi_host_wr_type  host_wr,
   output wire logic                        irq_line
);
   // board pull-up: released line reads high, asserted line reads low
   assign irq_line = irq_oe ? irq_o : 1'b1;

   initial begin
      host_wr = '0;
   end

   // one-cycle strobe, raised just after an edge, dropped after the next
   task automatic strobe(input rtpi_pkg::rtpi_host_wr_type w);
      @(posedge clk);
      #1 host_wr = w;
      @(posedge clk);
      #1 host_wr = '0;
   endtask

   // control write arms halt detection by clearing the halt flag
   task automatic wr_ctrl();
      strobe('{cyc_wr: 1'b0, cyc_data: 4'h0, ctrl_wr: 1'b1,
               pif_wr: 1'b0, pif_data: 1'b0});
   endtask

   // interrupt cycle select write
   task automatic wr_cyc(input logic [3:0] d);
      strobe('{cyc_wr: 1'b1, cyc_data: d, ctrl_wr: 1'b0,
               pif_wr: 1'b0, pif_data: 1'b0});
   endtask

   // flag write; zero is the acknowledge in level mode
   task automatic wr_pif(input logic b);
      strobe('{cyc_wr: 1'b0, cyc_data: 4'h0, ctrl_wr: 1'b0,
               pif_wr: 1'b1, pif_data: b});
   endtask
endmodule
`default_nettype wire

/* File: testbench/rtc_periodic_irq_and_osc_halt_tb_top.sv */
// self-checking bench of the periodic irq and oscillator halt block
`timescale 1ns/100ps
`default_nettype none
module rtc_periodic_irq_and_osc_halt_tb_top;
   localparam int unsigned HC = 20;  // shortened halt timeout
   localparam int unsigned MC = 200; // shortened measurement hold
   typedef struct {string name; logic [31:0] val;} rtpi_note_type;

   logic                        clk;      // 50 MHz
   logic                        reset_n;  // async, active low
   logic                        ce;       // access enable pin
   logic                        osc_input;
   logic                        osc_run;  // crystal running
   rtpi_pkg::rtpi_host_wr_type  host_wr;
   rtpi_pkg::rtpi_time_evt_type time_evt;
   logic                        irq_o, irq_oe, halt, pif;
   logic [3:0]                  sel;
   wire                         irq_line;
   logic [31:0]                 hi_cnt;   // cycles with line pulled low
   logic [31:0]                 chg_cnt;  // line transitions seen
   int                          error_cnt = 0;
   int                          checks = 0;
   int                          seed = 32'h0F3A;
   int                          other;    // non-selected boundary
   logic                        rb;       // random don't-care select bit
   rtpi_note_type               q[$];     // expected results, oldest first
   rtpi_note_type               nt;

   rtpi_core #(.HALT_CYC(HC), .MEAS_CYC(MC)) rtpi_core_inst (
      .CLK(clk), .RESET_N(reset_n), .CE(ce), .OSC_INPUT(osc_input),
      .HOST_WR(host_wr), .TIME_EVT(time_evt), .IRQ_OUT_N_O(irq_o),
      .IRQ_OUT_N_OE(irq_oe), .OSC_HALT_FLAG(halt),
      .PERIODIC_IRQ_FLAG(pif), .INTERRUPT_CYCLE_SELECT(sel));

   rtpi_host_model rtpi_host_model_inst (
      .clk(clk), .irq_o(irq_o), .irq_oe(irq_oe), .host_wr(host_wr),
      .irq_line(irq_line));

   // clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // crystal: one rising edge every two clocks keeps long divides short;
   // run enable read at the edge so bench updates just after never race
   always @(posedge clk) begin
      if (osc_run) osc_input <= #1 ~osc_input;
   end

   // one compare task per kind of result
   task automatic cmp(input string n, input logic [31:0] e,
                      input logic [31:0] s);
      checks++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value %s expected %0h seen %0h", n, e, s);
      end
   endtask
   task automatic cmp_bit(input string n, input logic e, input logic s);
      cmp(n, {31'h0, e}, {31'h0, s});
   endtask
   task automatic cmp_cnt(input string n, input logic [31:0] e,
                          input logic [31:0] s);
      cmp(n, e, s);
   endtask

   // watcher: takes the oldest note and compares it to the outputs
   always @(negedge clk) begin
      if (q.size() > 0) begin
         nt = q.pop_front();
         case (nt.name)
            "halt":  cmp_bit(nt.name, nt.val[0], halt);
            "pif":   cmp_bit(nt.name, nt.val[0], pif);
            "line":  cmp_bit(nt.name, nt.val[0], irq_line);
            "sel":   cmp(nt.name, nt.val, {28'h0, sel});
            "slow":  cmp_bit(nt.name, nt.val[0], chg_cnt < 2);
            default: cmp_cnt(nt.name, nt.val, hi_cnt);
         endcase
      end
   end

   task automatic note(input string n, input logic [31:0] v);
      q.push_back('{n, v});
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // counts low cycles and edges of the pulled-up line
   task automatic watch(input int n);
      logic last;
      hi_cnt = 0;
      chg_cnt = 0;
      last = irq_line;
      repeat (n) begin
         @(posedge clk);
         #1;
         hi_cnt += (irq_line === 1'b0);
         chg_cnt += (irq_line !== last);
         last = irq_line;
      end
   endtask
   task automatic pulse(input int b);
      time_evt = 8'(1 << b);
      step(1);
      time_evt = '0;
   endtask

   task automatic wrap_up();
      error_cnt += q.size(); // notes never compared count as misses
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // watchdog well past the expected run length
   initial begin
      repeat (100000) @(posedge clk);
      error_cnt++;
      wrap_up();
   end

   initial begin
      ce = 1'b0;
      osc_input = 1'b0;
      osc_run = 1'b1;
      time_evt = '0;
      reset_n = 1'b0;
      repeat (6) @(posedge clk);
      #1 reset_n = 1'b1;
      note("halt", 1);
      note("pif", 0);
      note("sel", 0);
      note("line", 1);
      step(2);
      // halt detection armed, then a stopped crystal, then a restart
      rtpi_host_model_inst.wr_ctrl();
      step(2);
      note("halt", 0);
      step(60);
      note("halt", 0);
      osc_run = 1'b0;
      step(HC + 8);
      note("halt", 1);
      osc_run = 1'b1;
      step(60);
      note("halt", 1);
      rtpi_host_model_inst.wr_ctrl();
      // short enable: detection frozen; code 01 holds the line low, so an
      // early measurement output would show up as released cycles
      rtpi_host_model_inst.wr_cyc(4'h1);
      ce = 1'b1;
      step(4);
      osc_run = 1'b0;
      watch(MC / 2);
      note("cnt", MC / 2);
      note("halt", 0);
      osc_run = 1'b1;
      step(4);
      ce = 1'b0;
      step(4);
      // pulse mode codes; bit 2 random as it is a don't-care
      for (int c = 0; c < 4; c++) begin
         rb = 1'($random(seed));
         rtpi_host_model_inst.wr_cyc({1'b0, rb, 2'(c)});
         step(3);
         note("sel", {29'h0, rb, 2'(c)});
         if (c < 2) begin
            note("line", 32'(c == 0));
            note("pif", 32'(c == 1));
            rtpi_host_model_inst.wr_pif(1'(c == 0));
            step(2);
            note("pif", 32'(c == 1));
         end else if (c == 2) begin
            watch(128);
            note("cnt", 64);
         end else begin
            watch(200);
            note("slow", 1);
         end
      end
      // level mode: each code against a wrong boundary, then its own
      for (int c = 0; c < 8; c++) begin
         other = (c + 1 + ($unsigned($random(seed)) % 7)) % 8;
         rtpi_host_model_inst.wr_cyc(4'h8 | 4'(c));
         step(2);
         pulse(other);
         step(3);
         note("pif", 0);
         pulse(c);
         step(3);
         note("pif", 1);
         note("line", 0);
         rtpi_host_model_inst.wr_pif(1'b0);
         step(3);
         note("line", 1);
      end
      rtpi_host_model_inst.wr_pif(1'b1);
      step(3);
      note("line", 0);
      rtpi_host_model_inst.wr_pif(1'b0);
      rtpi_host_model_inst.wr_cyc(4'h0);
      // long enable: 1 Hz measurement, exactly half of each second low
      ce = 1'b1;
      step(MC + 8);
      watch(65536);
      note("cnt", 32768);
      ce = 1'b0;
      step(6);
      watch(50);
      note("cnt", 0);
      step(4);
      wrap_up();
   end
endmodule
`default_nettype wire
